// ### spi_pin_port.sv
`timescale 1ns/1ps
`include "spi_pin_defs.svh"
module spi_pin_port
#(
  parameter int word_bits = `SP_WORD_BITS
)
(
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic sclk_in,
  input wire logic cs_b_in,
  input wire logic din_in,
  input wire logic user_pin_one_in,
  input wire logic pass_thru_in,
  input wire spi_pin_pkg::word_t tx_word_in,
  output logic dout_out,
  output logic dout_oe_out,
  output spi_pin_pkg::word_t rx_word_out,
  output logic rx_valid_out,
  output logic tx_load_out
);
  import spi_pin_pkg::*;
  // ----------------------------------------
  // Synchronised pins
  // ----------------------------------------
  logic sclk_s;
  logic cs_b_s;
  logic din_s;
  logic upin_s;
  logic [3:0] raw_pins;
  logic [3:0] sync_pins;
  assign raw_pins = {sclk_in, cs_b_in, din_in, user_pin_one_in};
  // One synchroniser per pin
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_sync
      pin_sync u_sync
      (
        .mclk_in(mclk_in),
        .rst_b_in(rst_b_in),
        .rst_val_in(1'b0),
        .pin_in(raw_pins[gi]),
        .level_out(sync_pins[gi])
      );
    end
  endgenerate
  assign {sclk_s, cs_b_s, din_s, upin_s} = sync_pins;
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed
  {
    link_state_t st;
    logic sclk_prev;
    logic cs_seen;
    logic [2:0] bit_cnt;
    word_t rx_sh;
    word_t tx_sh;
    word_t rx_word;
    logic rx_valid;
    logic tx_load;
    logic dout;
    logic dout_oe;
  } port_state_t;
  port_state_t s_q;
  port_state_t s_d;
  logic rise;
  logic fall;
  assign rise = sclk_s && !s_q.sclk_prev;
  assign fall = !sclk_s && s_q.sclk_prev;
  // Next-state logic for the whole port
  always_comb
  begin
    s_d = s_q;
    s_d.sclk_prev = sclk_s;
    s_d.rx_valid = 1'b0;
    s_d.tx_load = 1'b0;
    // The cs synchroniser starts at zero; wait for one real high first
    if (cs_b_s)
    begin
      s_d.cs_seen = 1'b1;
    end
    case (s_q.st)
      st_idle:
      begin
        // Frame opens on chip select low; first bit put on the line
        if (!cs_b_s && s_q.cs_seen)
        begin
          s_d.st = st_frame;
          s_d.bit_cnt = 3'h0;
          s_d.tx_sh = tx_word_in;
          s_d.tx_load = 1'b1;
        end
      end
      st_frame:
      begin
        if (cs_b_s)
        begin
          s_d.st = st_idle;
        end
        else
        begin
          if (rise)
          begin
            s_d.rx_sh = {s_q.rx_sh[6:0], din_s};
            s_d.bit_cnt = s_q.bit_cnt + 3'h1;
            if (s_q.bit_cnt == 3'h7)
            begin
              s_d.rx_word = {s_q.rx_sh[6:0], din_s};
              s_d.rx_valid = 1'b1;
            end
          end
          if (fall)
          begin
            if (s_q.bit_cnt == 3'h0)
            begin
              s_d.tx_sh = tx_word_in;
              s_d.tx_load = 1'b1;
            end
            else
            begin
              s_d.tx_sh = {s_q.tx_sh[6:0], 1'b0};
            end
          end
        end
      end
      default:
      begin
        s_d.st = st_idle;
      end
    endcase
    if (pass_thru_in)
    begin
      s_d.dout = upin_s;
      s_d.dout_oe = 1'b1;
    end
    else
    begin
      s_d.dout = s_d.tx_sh[7];
      s_d.dout_oe = (s_d.st == st_frame);
    end
  end
  // State register
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end
  assign dout_out = s_q.dout;
  assign dout_oe_out = s_q.dout_oe;
  assign rx_word_out = s_q.rx_word;
  assign rx_valid_out = s_q.rx_valid;
  assign tx_load_out = s_q.tx_load;
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_float_deselect: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    (cs_b_s && !pass_thru_in) |=> !dout_oe_out)
    else $error("dout driven while deselected");
  a_pass_follow: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    pass_thru_in |=> (dout_oe_out && dout_out == $past(upin_s)))
    else $error("pass-through does not follow user pin");
  a_rx_on_rise: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    (s_q.st == st_frame && !cs_b_s && rise) |=> s_q.rx_sh[0] == $past(din_s))
    else $error("input bit not captured on rise");
  a_no_shift_idle: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    (s_q.st == st_idle) |=> $stable(s_q.rx_sh))
    else $error("shift while deselected");
  a_tx_on_fall: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    (s_q.st == st_frame && !cs_b_s && !pass_thru_in && !fall) |=> $stable(dout_out))
    else $error("output changed without falling edge");
  a_word_pulse: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    rx_valid_out |=> !rx_valid_out)
    else $error("rx valid longer than one cycle");
  a_word_value: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    rx_valid_out |-> rx_word_out == s_q.rx_sh)
    else $error("word differs from shift register");
  a_frame_drive: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    (s_q.st == st_frame && !cs_b_s) |=> dout_oe_out)
    else $error("dout not driven in frame");
  c_frame: cover property (@(posedge mclk_in) s_q.st == st_frame ##1 s_q.st == st_idle);
  c_word: cover property (@(posedge mclk_in) rx_valid_out);
  c_pass: cover property (@(posedge mclk_in) pass_thru_in && dout_out);
  // Frame cut short in mid-word
  c_cut: cover property (@(posedge mclk_in) s_q.st == st_frame && cs_b_s && s_q.bit_cnt != 3'h0);
endmodule

// ### spi_pin_defs.svh
`ifndef SPI_PIN_DEFS_SVH
`define SPI_PIN_DEFS_SVH
// ----------------------------------------
// Widths, timing counts and reset values
// ----------------------------------------
// Bits per serial word
`define SP_WORD_BITS 8
// Synchroniser depth for pin inputs
`define SP_SYNC_DEPTH 3
// Reset value of the shift registers
`define SP_SHIFT_RESET 8'h00
`endif

// ### spi_pin_pkg.sv
package spi_pin_pkg;
  // Serial word carried on the pins
  typedef logic [7:0] word_t;
  // Link phase within a frame
  typedef enum logic [1:0] {st_idle, st_frame} link_state_t;
endpackage

// ### pin_sync.sv
`timescale 1ns/1ps
`include "spi_pin_defs.svh"
// Three-stage synchroniser; output moves when stages two and three agree
module pin_sync
(
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic rst_val_in,
  input wire logic pin_in,
  output logic level_out
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed
  {
    logic [2:0] stage;
    logic level;
  } sync_state_t;
  sync_state_t s_q;
  sync_state_t s_d;
  // Stage one only feeds stage two
  always_comb
  begin
    s_d = s_q;
    s_d.stage = {s_q.stage[1:0], pin_in};
    // Filter: accept a change only on agreement
    if (s_q.stage[1] == s_q.stage[2])
    begin
      s_d.level = s_q.stage[2];
    end
  end
  // Registers; reset clears every stage and the filtered level
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end
  assign level_out = s_q.level;
  // Reset level input not used: an async reset may load constants only
  logic unused_rst_val;
  assign unused_rst_val = rst_val_in;
endmodule

// ### host_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Host master on the serial link
// ----------------------------------------
module host_model
(
  input wire logic mclk_in,
  input wire logic dout_in,
  output logic sclk_out,
  output logic cs_b_out,
  output logic din_out
);
  import spi_pin_pkg::*;
  // Clock idles low outside frames, select released
  initial
  begin
    sclk_out = 1'b0;
    cs_b_out = 1'b1;
    din_out = 1'b0;
  end
  // Half period of 40 ns, the fastest legal pace
  task automatic half();
    repeat (10) @(negedge mclk_in);
  endtask
  // Eight bits MSB first; sel low makes stray edges only
  task automatic xfer(input word_t tx, input logic sel, output word_t rx);
    cs_b_out = ~sel;
    half();
    half();
    for (int i = 7; i >= 0; i--)
    begin
      din_out = tx[i];
      half();
      sclk_out = 1'b1;
      rx[i] = dout_in;
      half();
      sclk_out = 1'b0;
    end
    half();
    cs_b_out = 1'b1;
    // Released line shows the inverse, never a stale bit
    din_out = ~din_out;
    half();
  endtask
  // Frame cut short after n bits; the partial word is abandoned
  task automatic stub(input int n);
    cs_b_out = 1'b0;
    half();
    half();
    repeat (n)
    begin
      din_out = 1'b1;
      half();
      sclk_out = 1'b1;
      half();
      sclk_out = 1'b0;
    end
    half();
    cs_b_out = 1'b1;
    half();
  endtask
endmodule

// ### testbench.sv
`timescale 1ns/1ps
`define CHK(n, e, a) n_tests++; if ((a) !== (e)) begin $display("mismatch %s exp %h got %h", n, e, a); n_fail++; end
// ----------------------------------------
// Top of the bench
// ----------------------------------------
module testbench;
  import spi_pin_pkg::*;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic user_pin = 1'b0;
  logic pass = 1'b0;
  word_t tx_word = 8'h00;
  word_t got;
  logic sclk, cs_b, din, dout, dout_oe, rx_valid, tx_load;
  // Line seen by the host: a released pin shows the inverse, not a stale bit
  logic dout_line;
  assign dout_line = dout_oe ? dout : ~dout;
  // Pulse counters, sampled away from the launching edge
  int n_rxv = 0;
  int n_txl = 0;
  always @(negedge mclk)
  begin
    if (rx_valid === 1'b1)
      n_rxv++;
    if (tx_load === 1'b1)
      n_txl++;
  end
  word_t rx_word;
  int n_fail = 0;
  int n_tests = 0;
  // 250 MHz system clock
  always #2 mclk = ~mclk;
  host_model host (.mclk_in(mclk), .dout_in(dout_line), .sclk_out(sclk), .cs_b_out(cs_b),
    .din_out(din));
  spi_pin_port DUT (.mclk_in(mclk), .rst_b_in(rst_b), .sclk_in(sclk), .cs_b_in(cs_b),
    .din_in(din), .user_pin_one_in(user_pin), .pass_thru_in(pass), .tx_word_in(tx_word),
    .dout_out(dout), .dout_oe_out(dout_oe), .rx_word_out(rx_word),
    .rx_valid_out(rx_valid), .tx_load_out(tx_load));
  // Verdict and end of run
  task automatic wrap_up();
    if (n_fail == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // One full frame, both directions
  task automatic t_frames(input word_t a, input word_t b);
    int rx0;
    int tl0;
    @(negedge mclk);
    tx_word = a;
    rx0 = n_rxv;
    tl0 = n_txl;
    host.xfer(b, 1'b1, got);
    `CHK("dout bits", a, got)
    `CHK("rx word", b, rx_word)
    `CHK("rx pulses", 1, n_rxv - rx0)
    `CHK("tx loads", 2, n_txl - tl0)
  endtask
  // Edges while deselected change nothing
  task automatic t_desel();
    int rx0;
    int tl0;
    rx0 = n_rxv;
    tl0 = n_txl;
    `CHK("oe idle", 1'b0, dout_oe)
    host.xfer(8'hff, 1'b0, got);
    `CHK("rx held", 8'hc3, rx_word)
    `CHK("oe after", 1'b0, dout_oe)
    `CHK("desel pulses", 0, n_rxv - rx0)
    `CHK("desel loads", 0, n_txl - tl0)
  endtask
  // Cut frame drops its partial word; next frame restarts cleanly
  task automatic t_cut();
    int rx0;
    int tl0;
    @(negedge mclk);
    rx0 = n_rxv;
    tl0 = n_txl;
    host.stub(3);
    `CHK("cut pulses", 0, n_rxv - rx0)
    `CHK("cut loads", 1, n_txl - tl0)
    `CHK("cut rx held", 8'hc3, rx_word)
    `CHK("cut oe off", 1'b0, dout_oe)
    t_frames(8'h96, 8'h69);
  endtask
  // Pass-through follows user pin one both ways
  task automatic t_pass();
    for (int v = 1; v >= 0; v--)
    begin
      @(negedge mclk);
      pass = 1'b1;
      user_pin = v[0];
      repeat (10) @(negedge mclk);
      `CHK("pass dout", v[0], dout)
      `CHK("pass oe", 1'b1, dout_oe)
    end
    pass = 1'b0;
    repeat (10) @(negedge mclk);
    `CHK("oe off", 1'b0, dout_oe)
  endtask
  // Main sequence
  initial
  begin
    repeat (5) @(negedge mclk);
    rst_b = 1'b1;
    repeat (10) @(negedge mclk);
    t_frames(8'ha5, 8'h3c);
    t_frames(8'h5a, 8'hc3);
    t_desel();
    t_cut();
    t_pass();
    wrap_up();
  end
endmodule
